// ### include/cis_pkg.sv
// Shared constants and types for the instruction subset execution unit.
// Assumes a Wishbone classic master with 32-bit data and byte addressing.
package cis_pkg;

  // ----------------------------------------------------------------
  // Bus carrier
  // ----------------------------------------------------------------
  localparam int WB_AW = 12;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [WB_AW-1:0] adr;
    logic [31:0] dat;
  } cis_wb_req_type;

  // ----------------------------------------------------------------
  // Register map (word indices) and windows
  // ----------------------------------------------------------------
  localparam logic [3:0] REGION_REGS = 4'h0;
  localparam logic [3:0] REGION_FILE = 4'h1;
  localparam logic [3:0] REGION_HOLD = 4'h2;
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_INSTR = 6'h01;
  localparam logic [5:0] IDX_WREG = 6'h02;
  localparam logic [5:0] IDX_STATUS = 6'h03;
  localparam logic [5:0] IDX_TABLE_LATCH = 6'h04;
  localparam logic [5:0] IDX_TABLE_POINTER = 6'h05;
  localparam logic [5:0] IDX_BANK_SELECT = 6'h06;
  localparam logic [5:0] IDX_POINTER_TWO = 6'h07;
  localparam logic [5:0] IDX_STACK_TOP = 6'h08;
  localparam logic [5:0] IDX_PC = 6'h09;
  localparam int CTRL_START = 0;
  localparam int CTRL_EXT = 1;
  localparam int CTRL_TWO_WORD = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ZERO = 1;
  localparam int STAT_NEG = 2;
  localparam int STAT_SKIP = 3;

  // ----------------------------------------------------------------
  // Instruction fields and encodings
  // ----------------------------------------------------------------
  localparam int ACC_BIT = 8;
  localparam int DEST_BIT = 9;
  localparam int FSR_SUB_BIT = 8;
  localparam logic [13:0] OPC_TABLE_WRITE = 14'h0003;
  localparam logic [1:0] TBL_POST_INC = 2'h1;
  localparam logic [1:0] TBL_POST_DEC = 2'h2;
  localparam logic [1:0] TBL_PRE_INC = 2'h3;
  localparam logic [7:0] OPC_XOR_LITERAL = 8'h0A;
  localparam logic [5:0] OPC_XOR_REGISTER = 6'h06;
  localparam logic [6:0] OPC_TEST_SKIP = 7'h33;
  localparam logic [6:0] OPC_POINTER_ARITH = 7'h74;
  localparam logic [1:0] FSR_SEL_TWO = 2'h2;
  localparam logic [1:0] FSR_SEL_RETURN = 2'h3;
  localparam logic [7:0] ACCESS_LIMIT = 8'h5F;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [1:0] EXTRA_NONE = 2'h0;
  localparam logic [1:0] EXTRA_ONE = 2'h1;
  localparam logic [1:0] EXTRA_TWO = 2'h2;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] PTR_STEP = 21'h000001;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_DECODE = 5'b00010,
    ST_READ = 5'b00100,
    ST_PROC = 5'b01000,
    ST_WRITE = 5'b10000
  } cis_phase_type;

  typedef enum logic [2:0] {
    OP_NOP,
    OP_TABLE_WRITE,
    OP_TEST_SKIP,
    OP_XOR_LITERAL,
    OP_XOR_REGISTER,
    OP_POINTER
  } cis_op_type;

endpackage : cis_pkg

// ### rtl/cis_exec.sv
// Execution unit for table write, test-and-skip, exclusive-OR and pointer-two forms.
// Assumes a Wishbone classic master; one instruction is run per start command.
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Post-increment: write holding byte, then pointer plus one
// - Pre-increment: pointer plus one, then write holding byte
// - Test register: zero skips next one or two words, flags kept
// - Test register takes one, two or three cycles
// - Literal exclusive-OR into working register, one cycle
// - Register exclusive-OR with working register, one cycle
// - Destination bit set stores to register, else working
// - Access bit zero: access bank; one: bank select
// - Extension, access zero, field up to 5Fh: indexed
// - Extended features off unless enable bit set
// - Pointer-two add/subtract return loads program counter
// - Each cycle: decode, read, process, write phases
// - Table pointer bit zero selects low/high byte
module cis_exec
  import cis_pkg::*;
#(
  parameter int FILE_AW = 5,
  parameter int HOLD_AW = 6
)(
  input wire logic clk,
  input wire logic resetn,
  input wire cis_wb_req_type wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic busy,
  output var cis_phase_type phase
);

  // Each memory window holds at most 64 words on the bus
  if (FILE_AW < 1 || FILE_AW > 6 || HOLD_AW < 1 || HOLD_AW > 6)
  begin : g_bad_size
    $error("cis_exec: memory address widths must lie in 1..6");
  end

  localparam int FILE_DEPTH = 1 << FILE_AW;
  localparam int HOLD_DEPTH = 1 << HOLD_AW;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic cis_op_type op_of(input logic [15:0] iw, input logic ext);
    op_of = OP_NOP;
    if (iw[15:2] == OPC_TABLE_WRITE)
      op_of = OP_TABLE_WRITE;
    else if (iw[15:9] == OPC_TEST_SKIP)
      op_of = OP_TEST_SKIP;
    else if (iw[15:8] == OPC_XOR_LITERAL)
      op_of = OP_XOR_LITERAL;
    else if (iw[15:10] == OPC_XOR_REGISTER)
      op_of = OP_XOR_REGISTER;
    else if (iw[15:9] == OPC_POINTER_ARITH && ext)
      op_of = OP_POINTER;
  endfunction : op_of

  function automatic logic [11:0] eff_addr(input logic [15:0] iw, input logic ext,
                                           input logic [3:0] bank, input logic [11:0] ptr2);
    if (iw[ACC_BIT])
      eff_addr = {bank, iw[7:0]};
    else if (iw[7:0] <= ACCESS_LIMIT)
      eff_addr = ext ? ptr2 + {4'h0, iw[7:0]} : {4'h0, iw[7:0]};
    else
      eff_addr = {ACCESS_HIGH_BANK, iw[7:0]};
  endfunction : eff_addr

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    for (int b = 0; b < 4; b++)
      merge[8*b +: 8] = sel[b] ? wd[8*b +: 8] : old[8*b +: 8];
  endfunction : merge

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] instr, next_instr;
  logic [7:0] wreg, next_wreg;
  logic [7:0] table_latch, next_table_latch;
  logic [20:0] table_pointer, next_table_pointer;
  logic [3:0] bank_select_register, next_bank_select_register;
  logic [11:0] indirect_pointer_two, next_indirect_pointer_two;
  logic [20:0] stack_top, next_stack_top;
  logic [20:0] pc, next_pc;
  logic extension_enable_bit, next_extension_enable_bit;
  logic two_word, next_two_word;
  logic zflag, next_zflag;
  logic nflag, next_nflag;
  logic skip, next_skip;
  cis_op_type op, next_op;
  logic [11:0] addr, next_addr;
  logic [7:0] operand, next_operand;
  logic [7:0] result, next_result;
  logic [1:0] cyc_idx, next_cyc_idx;
  logic [1:0] cyc_total, next_cyc_total;
  logic [7:0] file_mem [FILE_DEPTH];
  logic [7:0] next_file_mem [FILE_DEPTH];
  logic [7:0] hold_mem [HOLD_DEPTH];
  logic [7:0] next_hold_mem [HOLD_DEPTH];
  cis_phase_type next_phase;
  logic next_busy;
  logic next_ack;
  logic [31:0] next_dat;
  logic [31:0] rd_word;
  logic accept;
  logic commit;
  logic [3:0] region;
  logic [5:0] widx;
  logic [FILE_AW-1:0] fidx;
  logic [HOLD_AW-1:0] hidx;
  logic [31:0] wmerged;

  assign accept = wb_req.cyc && wb_req.stb && !wb_ack_o;
  assign commit = wb_req.cyc && wb_req.stb && wb_req.we && wb_ack_o && !busy;
  assign region = wb_req.adr[11:8];
  assign widx = wb_req.adr[7:2];
  assign fidx = addr[FILE_AW-1:0];
  assign hidx = table_pointer[HOLD_AW-1:0];

  // ----------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_word = 32'h00000000;
    if (region == REGION_FILE)
      rd_word = {24'h000000, file_mem[widx[FILE_AW-1:0]]};
    else if (region == REGION_HOLD)
      rd_word = {24'h000000, hold_mem[widx[HOLD_AW-1:0]]};
    else if (region == REGION_REGS)
    begin
      case (widx)
        IDX_CTRL: rd_word[CTRL_TWO_WORD:CTRL_EXT] = {two_word, extension_enable_bit};
        IDX_INSTR: rd_word[15:0] = instr;
        IDX_WREG: rd_word[7:0] = wreg;
        IDX_STATUS: rd_word[STAT_SKIP:STAT_BUSY] = {skip, nflag, zflag, busy};
        IDX_TABLE_LATCH: rd_word[7:0] = table_latch;
        IDX_TABLE_POINTER: rd_word[20:0] = table_pointer;
        IDX_BANK_SELECT: rd_word[3:0] = bank_select_register;
        IDX_POINTER_TWO: rd_word[11:0] = indirect_pointer_two;
        IDX_STACK_TOP: rd_word[20:0] = stack_top;
        IDX_PC: rd_word[20:0] = pc;
        default: rd_word = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic: bus slave and execution phases
  // ----------------------------------------------------------------
  always_comb
  begin
    next_instr = instr;
    next_wreg = wreg;
    next_table_latch = table_latch;
    next_table_pointer = table_pointer;
    next_bank_select_register = bank_select_register;
    next_indirect_pointer_two = indirect_pointer_two;
    next_stack_top = stack_top;
    next_pc = pc;
    next_extension_enable_bit = extension_enable_bit;
    next_two_word = two_word;
    next_zflag = zflag;
    next_nflag = nflag;
    next_skip = skip;
    next_op = op;
    next_addr = addr;
    next_operand = operand;
    next_result = result;
    next_cyc_idx = cyc_idx;
    next_cyc_total = cyc_total;
    next_file_mem = file_mem;
    next_hold_mem = hold_mem;
    next_phase = phase;
    next_ack = accept;
    next_dat = accept ? rd_word : wb_dat_o;
    wmerged = merge(rd_word, wb_req.dat, wb_req.sel);

    // Writes are refused while an instruction runs so software never races it
    if (commit)
    begin
      if (region == REGION_FILE && wb_req.sel[0])
        next_file_mem[widx[FILE_AW-1:0]] = wb_req.dat[7:0];
      else if (region == REGION_HOLD && wb_req.sel[0])
        next_hold_mem[widx[HOLD_AW-1:0]] = wb_req.dat[7:0];
      else if (region == REGION_REGS)
      begin
        case (widx)
          IDX_CTRL:
          begin
            if (wb_req.sel[0])
            begin
              next_extension_enable_bit = wb_req.dat[CTRL_EXT];
              next_two_word = wb_req.dat[CTRL_TWO_WORD];
              if (wb_req.dat[CTRL_START])
              begin
                next_phase = ST_DECODE;
                next_cyc_idx = EXTRA_NONE;
                next_skip = 1'b0;
              end
            end
          end
          IDX_INSTR: next_instr = wmerged[15:0];
          IDX_WREG: next_wreg = wmerged[7:0];
          IDX_TABLE_LATCH: next_table_latch = wmerged[7:0];
          IDX_TABLE_POINTER: next_table_pointer = wmerged[20:0];
          IDX_BANK_SELECT: next_bank_select_register = wmerged[3:0];
          IDX_POINTER_TWO: next_indirect_pointer_two = wmerged[11:0];
          IDX_STACK_TOP: next_stack_top = wmerged[20:0];
          default: next_pc = pc;
        endcase
      end
    end

    // Later cycles of a multi-cycle instruction step phases only, but for the table write's hold write and post-step in cycle two and the final pc update
    unique case (phase)
      ST_IDLE: next_busy = next_phase != ST_IDLE;
      ST_DECODE:
      begin
        if (cyc_idx == EXTRA_NONE)
        begin
          next_op = op_of(instr, extension_enable_bit);
          next_addr = eff_addr(instr, extension_enable_bit, bank_select_register,
                               indirect_pointer_two);
          next_cyc_total = EXTRA_NONE;
          if (next_op == OP_TABLE_WRITE ||
              (next_op == OP_POINTER && instr[7:6] == FSR_SEL_RETURN))
            next_cyc_total = EXTRA_ONE;
        end
        next_phase = ST_READ;
      end
      ST_READ:
      begin
        if (cyc_idx == EXTRA_NONE)
        begin
          if (op == OP_XOR_LITERAL)
            next_operand = instr[7:0];
          else
            next_operand = file_mem[fidx];
        end
        next_phase = ST_PROC;
      end
      ST_PROC:
      begin
        if (cyc_idx == EXTRA_NONE)
        begin
          unique case (op)
            OP_XOR_LITERAL, OP_XOR_REGISTER:
            begin
              next_result = wreg ^ operand;
              next_zflag = (wreg ^ operand) == 8'h00;
              next_nflag = wreg[7] ^ operand[7];
            end
            OP_TEST_SKIP:
            begin
              next_skip = operand == 8'h00;
              if (operand == 8'h00)
                next_cyc_total = two_word ? EXTRA_TWO : EXTRA_ONE;
            end
            OP_TABLE_WRITE:
            begin
              if (instr[1:0] == TBL_PRE_INC)
                next_table_pointer = table_pointer + PTR_STEP;
            end
            OP_POINTER, OP_NOP: next_result = result;
          endcase
        end
        next_phase = ST_WRITE;
      end
      ST_WRITE:
      begin
        if (cyc_idx == EXTRA_NONE)
        begin
          if (op == OP_XOR_LITERAL)
            next_wreg = result;
          else if (op == OP_XOR_REGISTER && instr[DEST_BIT])
            next_file_mem[fidx] = result;
          else if (op == OP_XOR_REGISTER)
            next_wreg = result;
          else if (op == OP_POINTER && instr[7:6] >= FSR_SEL_TWO)
            next_indirect_pointer_two = instr[FSR_SUB_BIT]
              ? indirect_pointer_two - {6'h00, instr[5:0]}
              : indirect_pointer_two + {6'h00, instr[5:0]};
        end
        if (cyc_idx == EXTRA_ONE && op == OP_TABLE_WRITE)
        begin
          next_hold_mem[hidx] = table_latch;
          if (instr[1:0] == TBL_POST_INC)
            next_table_pointer = table_pointer + PTR_STEP;
          else if (instr[1:0] == TBL_POST_DEC)
            next_table_pointer = table_pointer - PTR_STEP;
        end
        if (cyc_idx == cyc_total)
        begin
          next_phase = ST_IDLE;
          if (op == OP_POINTER && instr[7:6] == FSR_SEL_RETURN)
            next_pc = stack_top;
          else if (op == OP_TEST_SKIP && skip)
            next_pc = pc + PC_STEP + (two_word ? PC_STEP + PC_STEP : PC_STEP);
          else
            next_pc = pc + PC_STEP;
        end
        else
        begin
          next_cyc_idx = cyc_idx + EXTRA_ONE;
          next_phase = ST_DECODE;
        end
      end
    endcase
    next_busy = next_phase != ST_IDLE;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      instr <= 16'h0000;
      wreg <= 8'h00;
      table_latch <= 8'h00;
      table_pointer <= 21'h000000;
      bank_select_register <= 4'h0;
      indirect_pointer_two <= 12'h000;
      stack_top <= 21'h000000;
      pc <= 21'h000000;
      extension_enable_bit <= 1'b0;
      two_word <= 1'b0;
      zflag <= 1'b0;
      nflag <= 1'b0;
      skip <= 1'b0;
      op <= OP_NOP;
      addr <= 12'h000;
      operand <= 8'h00;
      result <= 8'h00;
      cyc_idx <= EXTRA_NONE;
      cyc_total <= EXTRA_NONE;
      for (int i = 0; i < FILE_DEPTH; i++)
        file_mem[i] <= 8'h00;
      for (int i = 0; i < HOLD_DEPTH; i++)
        hold_mem[i] <= 8'h00;
      phase <= ST_IDLE;
      busy <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      instr <= next_instr;
      wreg <= next_wreg;
      table_latch <= next_table_latch;
      table_pointer <= next_table_pointer;
      bank_select_register <= next_bank_select_register;
      indirect_pointer_two <= next_indirect_pointer_two;
      stack_top <= next_stack_top;
      pc <= next_pc;
      extension_enable_bit <= next_extension_enable_bit;
      two_word <= next_two_word;
      zflag <= next_zflag;
      nflag <= next_nflag;
      skip <= next_skip;
      op <= next_op;
      addr <= next_addr;
      operand <= next_operand;
      result <= next_result;
      cyc_idx <= next_cyc_idx;
      cyc_total <= next_cyc_total;
      file_mem <= next_file_mem;
      hold_mem <= next_hold_mem;
      phase <= next_phase;
      busy <= next_busy;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [2:0] decodes;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      decodes <= 3'h0;
    else if (phase == ST_IDLE)
      decodes <= 3'h0;
    else if (phase == ST_DECODE)
      decodes <= decodes + 3'h1;
  end

  logic last_write;
  assign last_write = phase == ST_WRITE && cyc_idx == cyc_total;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  post_inc_write_a: assert property (
    phase == ST_WRITE && op == OP_TABLE_WRITE && cyc_idx == EXTRA_ONE &&
    instr[1:0] == TBL_POST_INC
    |=> table_pointer == $past(table_pointer) + PTR_STEP &&
        hold_mem[$past(hidx)] == $past(table_latch))
    else $error("post-increment table write wrong");

  pre_inc_first_a: assert property (
    phase == ST_DECODE && cyc_idx == EXTRA_NONE && op_of(instr, extension_enable_bit)
    == OP_TABLE_WRITE && instr[1:0] == TBL_PRE_INC
    |=> ##7 hold_mem[table_pointer[HOLD_AW-1:0]] == table_latch &&
        table_pointer == $past(table_pointer, 7) + PTR_STEP)
    else $error("pre-increment table write wrong");

  skip_keeps_flags_a: assert property (
    phase == ST_PROC && op == OP_TEST_SKIP && cyc_idx == EXTRA_NONE
    |=> skip == ($past(operand) == 8'h00) && $stable(zflag) && $stable(nflag))
    else $error("test skip decision or flags wrong");

  skip_cycles_a: assert property (
    last_write && op == OP_TEST_SKIP
    |-> decodes == (!skip ? 3'h1 : two_word ? 3'h3 : 3'h2))
    else $error("test skip cycle count wrong");

  xor_literal_a: assert property (
    phase == ST_DECODE && cyc_idx == EXTRA_NONE &&
    op_of(instr, extension_enable_bit) == OP_XOR_LITERAL
    |=> ##3 wreg == ($past(wreg, 4) ^ $past(instr[7:0], 4)) && phase == ST_IDLE)
    else $error("literal exclusive-OR wrong");

  xor_dest_a: assert property (
    phase == ST_WRITE && op == OP_XOR_REGISTER
    |=> (instr[DEST_BIT] ? (wreg == $past(wreg) && file_mem[$past(fidx)] == $past(result))
                         : wreg == $past(result)))
    else $error("register exclusive-OR destination wrong");

  bank_select_a: assert property (
    phase == ST_READ && cyc_idx == EXTRA_NONE && instr[ACC_BIT] &&
    (op == OP_XOR_REGISTER || op == OP_TEST_SKIP)
    |-> addr == {bank_select_register, instr[7:0]})
    else $error("bank select addressing wrong");

  indexed_mode_a: assert property (
    phase == ST_READ && cyc_idx == EXTRA_NONE && !instr[ACC_BIT] &&
    extension_enable_bit && instr[7:0] <= ACCESS_LIMIT
    |-> addr == indirect_pointer_two + {4'h0, instr[7:0]})
    else $error("indexed literal offset addressing wrong");

  ext_disabled_a: assert property (
    phase == ST_READ && !extension_enable_bit |-> op != OP_POINTER)
    else $error("extended instruction ran while disabled");

  return_pc_a: assert property (
    last_write && op == OP_POINTER && instr[7:6] == FSR_SEL_RETURN
    |=> pc == $past(stack_top) && decodes == 3'h2)
    else $error("pointer-two return did not load stack top");

  phase_order_a: assert property (
    phase == ST_DECODE |=> phase == ST_READ ##1 phase == ST_PROC ##1 phase == ST_WRITE)
    else $error("instruction phases out of order");

  byte_select_a: assert property (
    phase == ST_WRITE && op == OP_TABLE_WRITE && cyc_idx == EXTRA_ONE
    |=> hold_mem[{$past(hidx[HOLD_AW-1:1]), $past(table_pointer[0])}] == $past(table_latch))
    else $error("table pointer byte select wrong");

  xor_flags_a: assert property (
    phase == ST_WRITE && cyc_idx == EXTRA_NONE &&
    (op == OP_XOR_LITERAL || op == OP_XOR_REGISTER)
    |-> zflag == (result == 8'h00) && nflag == result[7])
    else $error("exclusive-OR flags wrong");

  post_inc_c: cover property (last_write && op == OP_TABLE_WRITE && instr[1:0] == TBL_POST_INC);
  skip_two_c: cover property (last_write && op == OP_TEST_SKIP && skip && two_word);
  return_c: cover property (last_write && op == OP_POINTER && instr[7:6] == FSR_SEL_RETURN);
  xor_to_w_c: cover property (last_write && op == OP_XOR_REGISTER && !instr[DEST_BIT]);

endmodule : cis_exec

`default_nettype wire

// ### bench/tb_cpu_instruction_subset_exec.sv
// Self-checking bench for the instruction subset execution unit.
// Assumes cis_exec behind a Wishbone classic slave, types from cis_pkg.
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_instruction_subset_exec
  import cis_pkg::*;
();
  logic clk;
  logic resetn;
  cis_wb_req_type req;
  logic [31:0] dat;
  logic ack;
  logic busy;
  cis_phase_type phase;
  logic [31:0] q;
  int bad_count;
  int cmp_count;

  cis_exec dut (.clk(clk), .resetn(resetn), .wb_req(req), .wb_dat_o(dat),
    .wb_ack_o(ack), .busy(busy), .phase(phase));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  function automatic logic [11:0] ra(input logic [5:0] i);
    return {4'h0, i, 2'b00};
  endfunction : ra

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    q = dat;
    req <= '0;
  endtask : wb

  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(n, e, q);
  endtask : rd

  // Busy spans four clocks per instruction cycle, so it measures the cycle count
  task automatic run(input logic [15:0] i, input logic [2:0] c, input int cy);
    int n;
    n = 0;
    wb(1'b1, ra(IDX_INSTR), {16'h0, i});
    wb(1'b1, ra(IDX_CTRL), {29'h0, c});
    repeat (30)
    begin
      @(posedge clk);
      if (busy === 1'b1)
      begin
        n++;
        // Every instruction cycle opens with its decode phase
        if (n % 4 == 1)
          check("phase", 32'(ST_DECODE), 32'(phase));
      end
    end
    check("cycles", 32'(4 * cy), 32'(n));
    check("idle", 32'(ST_IDLE), 32'(phase));
  endtask : run

  task automatic tally_and_finish();
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    resetn = 1'b0;
    req = '0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd("pc", ra(IDX_PC), 32'h0);
    run(16'h6604, 3'h1, 2);
    rd("pc", ra(IDX_PC), 32'h4);
    rd("status", ra(IDX_STATUS), 32'h8);
    run(16'h6604, 3'h5, 3);
    rd("pc", ra(IDX_PC), 32'hA);
    wb(1'b1, 12'h110, 32'h1);
    run(16'h6604, 3'h1, 1);
    rd("pc", ra(IDX_PC), 32'hC);
    wb(1'b1, ra(IDX_WREG), 32'hB5);
    wb(1'b1, 12'h10C, 32'hAF);
    run(16'h1A03, 3'h1, 1);
    rd("file3", 12'h10C, 32'h1A);
    rd("w", ra(IDX_WREG), 32'hB5);
    rd("status", ra(IDX_STATUS), 32'h0);
    run(16'h1803, 3'h1, 1);
    rd("w", ra(IDX_WREG), 32'hAF);
    rd("status", ra(IDX_STATUS), 32'h4);
    run(16'h0AAF, 3'h1, 1);
    rd("w", ra(IDX_WREG), 32'h0);
    rd("status", ra(IDX_STATUS), 32'h2);
    run(16'h6604, 3'h1, 1);
    rd("status", ra(IDX_STATUS), 32'h2);
    // Same field with and without the extension must reach different bytes
    wb(1'b1, ra(IDX_WREG), 32'hFF);
    wb(1'b1, ra(IDX_POINTER_TWO), 32'h1);
    run(16'h1A02, 3'h1, 1);
    rd("file2", 12'h108, 32'hFF);
    run(16'h1A02, 3'h3, 1);
    rd("file3", 12'h10C, 32'hE5);
    wb(1'b1, ra(IDX_BANK_SELECT), 32'h2);
    run(16'h1B05, 3'h1, 1);
    rd("file5", 12'h114, 32'hFF);
    wb(1'b1, ra(IDX_STACK_TOP), 32'h100);
    run(16'hE8C5, 3'h3, 2);
    rd("pc", ra(IDX_PC), 32'h100);
    rd("ptr2", ra(IDX_POINTER_TWO), 32'h6);
    run(16'hE982, 3'h1, 1);
    rd("ptr2", ra(IDX_POINTER_TWO), 32'h6);
    run(16'hE982, 3'h3, 1);
    rd("ptr2", ra(IDX_POINTER_TWO), 32'h4);
    wb(1'b1, ra(IDX_TABLE_LATCH), 32'h55);
    wb(1'b1, ra(IDX_TABLE_POINTER), 32'hA356);
    run(16'h000D, 3'h1, 2);
    rd("hold16", 12'h258, 32'h55);
    rd("tptr", ra(IDX_TABLE_POINTER), 32'hA357);
    wb(1'b1, ra(IDX_TABLE_LATCH), 32'h34);
    wb(1'b1, ra(IDX_TABLE_POINTER), 32'h1389A);
    wb(1'b1, 12'h268, 32'hFF);
    wb(1'b1, 12'h26C, 32'hFF);
    run(16'h000F, 3'h1, 2);
    rd("hold1b", 12'h26C, 32'h34);
    rd("hold1a", 12'h268, 32'hFF);
    rd("tptr", ra(IDX_TABLE_POINTER), 32'h1389B);
    wb(1'b1, ra(IDX_TABLE_LATCH), 32'h77);
    run(16'h000E, 3'h1, 2);
    rd("hold1b", 12'h26C, 32'h77);
    rd("tptr", ra(IDX_TABLE_POINTER), 32'h1389A);
    rd("unmapped", 12'h0FC, 32'h0);
    tally_and_finish();
  end

  // Whole sequence needs about 700 clocks
  initial
  begin
    repeat (6000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule : tb_cpu_instruction_subset_exec
`default_nettype wire
